// >>> apb_host_model.sv
/*
 * Host CPU model: an APB master that issues register and array accesses.
 * Assumes a slave on i_ref_clk that answers with a registered pready.
 */
`timescale 1ns/1ps

module apb_host_model
	import flash_ctl_pkg::*;
(
	// Bus side.
	input  wire logic                    i_ref_clk,
	input  wire flash_ctl_pkg::apb_rsp_t i_apb,
	output flash_ctl_pkg::apb_req_t      o_apb
);
	initial o_apb = '0;

	// The request stays frozen until pready is seen high at an edge.
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		logic seen;
		seen = 1'b0;
		@(posedge i_ref_clk);
		o_apb.psel    <= 1'b1;
		o_apb.penable <= 1'b0;
		o_apb.pwrite  <= wr;
		o_apb.paddr   <= a;
		o_apb.pwdata  <= d;
		@(posedge i_ref_clk);
		o_apb.penable <= 1'b1;
		// The answer is looked at mid-cycle, where it has settled, and the
		// request is dropped only after the rising edge that samples it.
		while (!seen) begin
			@(negedge i_ref_clk);
			seen = (i_apb.pready === 1'b1);
			rd   = i_apb.prdata;
			err  = i_apb.pslverr;
			@(posedge i_ref_clk);
		end
		o_apb.psel    <= 1'b0;
		o_apb.penable <= 1'b0;
	endtask : xfer
endmodule : apb_host_model

// >>> flash_ctl_pkg.sv
/*
 * Package for the flash mode, security and interrupt controller: register
 * offsets, field positions, reset values, timing counts and carrier types.
 * Assumes an APB master with 32-bit data and word-aligned registers.
 */
package flash_ctl_pkg;

	// Register byte offsets.
	localparam logic [7:0] CFG_OFS   = 8'h00;
	localparam logic [7:0] STAT_OFS  = 8'h04;
	localparam logic [7:0] PROT_OFS  = 8'h08;
	localparam logic [7:0] SEC_OFS   = 8'h0c;
	localparam logic [7:0] KEY_OFS   = 8'h10;
	localparam logic [7:0] MODE_OFS  = 8'h14;
	localparam logic [7:0] OPT_OFS   = 8'h18;
	localparam logic [7:0] ARRAY_OFS = 8'h1c;

	// Configuration register fields.
	localparam int CFG_BE_IE  = 7;
	localparam int CFG_CC_IE  = 6;
	localparam int CFG_KEY_ACCESS_ACTIVE = 5;
	localparam int CFG_BANK_SELECT  = 0;

	// Status register fields.
	localparam int ST_BE   = 7;
	localparam int ST_CC   = 6;
	localparam int ST_PV   = 5;
	localparam int ST_AE   = 4;

	// Mode register fields (bdm, special single chip, stop, wait).
	localparam int MD_BDM  = 0;
	localparam int MD_SSC  = 1;
	localparam int MD_STOP = 2;
	localparam int MD_WAIT = 3;

	// Key write register: [17:16] key index, [15:0] key word.
	localparam int KEY_IDX_LSB = 16;

	// Security codes.
	localparam logic [1:0] SEC_UNSECURE = 2'h2;
	localparam logic [7:0] OPT_RESET    = 8'hff;
	localparam logic [7:0] PROT_RESET   = 8'hff;
	localparam int         OPT_BACKDOOR_ENABLE_LSB = 6;
	localparam logic [1:0] BACKDOOR_ENABLE_CODE   = 2'h2;

	// Commands.
	localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
	localparam logic [7:0] CMD_PROGRAM    = 8'h20;
	localparam logic [7:0] CMD_SECT_ERASE = 8'h40;
	localparam logic [7:0] CMD_VERIFY     = 8'h05;

	// Command execution time.
	localparam int CLK_MHZ       = 200;
	localparam int CMD_TIME_NS   = 100;
	localparam int CMD_CYCLES    = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W         = 8;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic be;
		logic cc;
		logic pv;
		logic ae;
	} bank_flags_t;

endpackage : flash_ctl_pkg

// >>> flash_power_security_irq.sv
/*
 * Flash command supervisor covering wait, stop, debug and reset behaviour,
 * backdoor key unsecuring and bank-qualified interrupt requests.
 * Assumes an APB master on i_ref_clk and a chip that reports its power and
 * debug mode through the mode register; the array itself is modelled only
 * by a busy timer and the stored key and option words come in as inputs.
 */
`timescale 1ns/1ps

module flash_power_security_irq
#(
	parameter int CMD_TICKS = flash_ctl_pkg::CMD_CYCLES
) (
	// Clock and reset.
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst,
	// APB slave.
	input  wire flash_ctl_pkg::apb_req_t  i_apb,
	output flash_ctl_pkg::apb_rsp_t       o_apb,
	// Stored array contents.
	input  wire logic [63:0]              i_backdoor_key,
	input  wire logic [7:0]               i_security_option,
	input  wire logic [31:0]              i_array_rdata,
	// Chip side.
	output logic                          o_irq,
	output logic                          o_high_voltage_on,
	output logic [1:0]                    o_security_state_field
);
	import flash_ctl_pkg::*;

	// The busy timer is CNT_W bits wide and cannot time longer commands.
	if (CMD_TICKS < 1 || CMD_TICKS > (1 << CNT_W) - 1) begin : g_ticks_chk
		$error("CMD_TICKS out of range");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_LOAD = 2'b10
	} seq_t;

	typedef struct packed {
		seq_t             seq;
		logic [CNT_W-1:0] cnt;
		logic             bank_run;
		logic             queued;
		logic [7:0]       cmd_q;
		logic [7:0]       cmd_run;
		bank_flags_t [1:0] fl;
		logic             bank_select;
		logic             be_ie;
		logic             cc_ie;
		logic             key_access_active;
		logic [3:0]       mode;
		logic [7:0]       prot;
		logic [1:0]       sec;
		logic [2:0]       key_idx;
		logic             key_bad;
		logic             key_via_dbg;
		logic             hv;
		logic             irq;
		logic             pready;
		logic [31:0]      prdata;
		logic             pslverr;
		logic             sec_loaded;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic [1:0] key_index(input logic [31:0] d);
		key_index = d[KEY_IDX_LSB +: 2];
	endfunction : key_index

	function automatic logic is_secured(input logic [1:0] sec);
		is_secured = (sec != SEC_UNSECURE);
	endfunction : is_secured

	logic        wr_acc;
	logic        rd_acc;
	logic [7:0]  addr;
	logic [31:0] wd;
	logic        lock;
	logic        stop_entry;
	logic        stop_exit;
	logic        backdoor_enable;
	logic        cmd_ok;
	logic [15:0] key_word;

	// Writes here are accepted and ignored rather than flagged as errors.
	localparam logic [7:0] CMD_OFS_GUARD = KEY_OFS + 8'h20;

	assign addr   = i_apb.paddr;
	assign wd     = i_apb.pwdata;
	assign wr_acc = i_apb.psel & i_apb.penable & i_apb.pwrite & ~s_q.pready;
	assign rd_acc = i_apb.psel & i_apb.penable & ~i_apb.pwrite & ~s_q.pready;
	assign backdoor_enable  = (i_security_option[OPT_BACKDOOR_ENABLE_LSB +: 2] == BACKDOOR_ENABLE_CODE);
	assign key_word = i_backdoor_key[16*key_index(wd) +: 16];

	always_comb begin
		s_d = s_q;
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;
		lock = s_q.fl[0].ae | s_q.fl[0].pv | s_q.fl[1].ae | s_q.fl[1].pv;
		stop_entry = 1'b0;
		stop_exit  = 1'b0;
		// Secured special mode only takes mass erase; debug unsecured all.
		cmd_ok = !(s_q.mode[MD_SSC] && is_secured(s_q.sec)) ||
			(s_q.cmd_q == CMD_MASS_ERASE);

		// Command engine; wait mode has no effect so work completes.
		case (s_q.seq)
		ST_RUN: begin
			if (s_q.cnt == CNT_W'(1)) begin
				if (s_q.queued && !lock) begin
					s_d.cmd_run = s_q.cmd_q;
					s_d.queued  = 1'b0;
					s_d.cnt     = CNT_W'(CMD_TICKS);
					s_d.fl[s_q.bank_run].be = 1'b1;
				end else begin
					s_d.seq = ST_IDLE;
					s_d.hv  = 1'b0;
					s_d.fl[s_q.bank_run].cc = 1'b1;
				end
			end else begin
				s_d.cnt = s_q.cnt - CNT_W'(1);
			end
		end
		ST_LOAD: begin
			s_d.seq = ST_RUN;
			s_d.cnt = CNT_W'(CMD_TICKS);
			s_d.hv  = 1'b1;
			s_d.cmd_run = s_q.cmd_q;
			s_d.queued  = 1'b0;
			s_d.fl[s_q.bank_run].be = 1'b1;
		end
		ST_IDLE: ;
		default: s_d.seq = ST_IDLE;
		endcase

		// Bus access.
		if (wr_acc || rd_acc)
			s_d.pready = 1'b1;
		if (wr_acc) begin
			case (addr)
			CFG_OFS: begin
				s_d.be_ie  = wd[CFG_BE_IE];
				s_d.cc_ie  = wd[CFG_CC_IE];
				s_d.bank_select  = wd[CFG_BANK_SELECT];
				s_d.key_access_active = wd[CFG_KEY_ACCESS_ACTIVE];
				if (wd[CFG_KEY_ACCESS_ACTIVE] && !s_q.key_access_active) begin
					s_d.key_idx = 3'h0;
					s_d.key_bad = 1'b0;
					s_d.key_via_dbg = 1'b0;
				end
				if (!wd[CFG_KEY_ACCESS_ACTIVE] && s_q.key_access_active) begin
					// Protection and stored words are left untouched.
					if (s_q.key_idx == 3'h4 && !s_q.key_bad &&
						!s_q.key_via_dbg)
						s_d.sec = SEC_UNSECURE;
				end
			end
			STAT_OFS: begin
				if (wd[ST_AE])
					s_d.fl[s_q.bank_select].ae = 1'b0;
				if (wd[ST_PV])
					s_d.fl[s_q.bank_select].pv = 1'b0;
				if (wd[ST_BE] && s_q.fl[s_q.bank_select].be && !lock) begin
					if (cmd_ok) begin
						s_d.fl[s_q.bank_select].be = 1'b0;
						s_d.fl[s_q.bank_select].cc = 1'b0;
						// A command ending in this very cycle must not leave
						// the new one queued behind an idle engine.
						if (s_d.seq == ST_IDLE) begin
							s_d.seq = ST_LOAD;
							s_d.bank_run = s_q.bank_select;
						end else begin
							s_d.queued = 1'b1;
						end
					end else begin
						s_d.fl[s_q.bank_select].ae = 1'b1;
					end
				end
			end
			PROT_OFS: begin
				if (s_q.mode[MD_BDM])
					s_d.prot = wd[7:0];
			end
			KEY_OFS: begin
				if (backdoor_enable && s_q.key_access_active) begin
					// Each word must arrive in order and match.
					if (key_index(wd) != s_q.key_idx[1:0] ||
						s_q.key_idx == 3'h4 || wd[15:0] != key_word)
						s_d.key_bad = 1'b1;
					if (s_q.key_idx != 3'h4)
						s_d.key_idx = s_q.key_idx + 3'h1;
					if (s_q.mode[MD_BDM] && s_q.mode[MD_SSC])
						s_d.key_via_dbg = 1'b1;
				end
			end
			MODE_OFS: begin
				s_d.mode = wd[3:0];
				stop_entry = wd[MD_STOP] & ~s_q.mode[MD_STOP];
				stop_exit  = ~wd[MD_STOP] & s_q.mode[MD_STOP];
			end
			CMD_OFS_GUARD: ;
			default: s_d.pslverr = 1'b1;
			endcase
			if (addr == ARRAY_OFS && s_q.fl[s_q.bank_select].be) begin
				s_d.cmd_q = wd[31:24];
				s_d.pslverr = 1'b0;
			end
		end

		if (stop_entry && s_q.seq != ST_IDLE) begin
			s_d.seq = ST_IDLE;
			s_d.hv  = 1'b0;
			s_d.fl[s_q.bank_run].cc = 1'b1;
			s_d.fl[s_q.bank_run].ae = 1'b1;
		end
		if (stop_exit) begin
			s_d.queued = 1'b0;
			s_d.fl[0].be = 1'b1;
			s_d.fl[1].be = 1'b1;
		end

		if (rd_acc) begin
			case (addr)
			CFG_OFS: s_d.prdata = {24'h0, s_q.be_ie, s_q.cc_ie, s_q.key_access_active,
				4'h0, s_q.bank_select};
			STAT_OFS: s_d.prdata = {24'h0, s_q.fl[s_q.bank_select].be,
				s_q.fl[s_q.bank_select].cc, s_q.fl[s_q.bank_select].pv,
				s_q.fl[s_q.bank_select].ae, 4'h0};
			PROT_OFS: s_d.prdata = {24'h0, s_q.prot};
			SEC_OFS:  s_d.prdata = {30'h0, s_q.sec};
			MODE_OFS: s_d.prdata = {28'h0, s_q.mode};
			OPT_OFS:  s_d.prdata = {24'h0, i_security_option};
			ARRAY_OFS: s_d.prdata = (s_q.key_access_active || s_q.seq != ST_IDLE) ?
				32'hffffffff : i_array_rdata;
			default: begin
				s_d.prdata  = 32'h0;
				s_d.pslverr = 1'b1;
			end
			endcase
		end

		// The option byte is taken once, on the first edge after reset, so
		// a backdoor unsecure lasts only until the next reset.
		s_d.sec_loaded = 1'b1;
		if (!s_q.sec_loaded)
			s_d.sec = i_security_option[1:0];

		// Only the selected bank's flags can raise a request.
		s_d.irq = (s_d.be_ie & s_d.fl[s_d.bank_select].be) |
			(s_d.cc_ie & s_d.fl[s_d.bank_select].cc);
	end

	// Reset clears any command; security comes back from the options.
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			s_q <= '{seq: ST_IDLE, fl: {4'b1100, 4'b1100}, prot: PROT_RESET,
				sec: 2'h3, default: '0};
		else
			s_q <= s_d;
	end

	assign o_apb = '{pready: s_q.pready, pslverr: s_q.pslverr,
		prdata: s_q.prdata};
	assign o_irq = s_q.irq;
	assign o_high_voltage_on = s_q.hv;
	assign o_security_state_field = s_q.sec;

	property p_stop_abort;
		@(posedge i_ref_clk) disable iff (i_rst)
		(stop_entry && s_q.seq != ST_IDLE) |=>
			(s_q.seq == ST_IDLE && !s_q.hv && s_q.fl[$past(s_q.bank_run)].ae);
	endproperty
	a_stop_abort: assert property (p_stop_abort)
		else $error("stop did not abort command");

	property p_stop_exit;
		@(posedge i_ref_clk) disable iff (i_rst)
		stop_exit |=> (!s_q.queued && s_q.fl[0].be && s_q.fl[1].be);
	endproperty
	a_stop_exit: assert property (p_stop_exit)
		else $error("stop exit did not drop queue");

	property p_lock;
		@(posedge i_ref_clk) disable iff (i_rst)
		(lock && s_q.seq == ST_IDLE) |=> s_q.seq != ST_LOAD;
	endproperty
	a_lock: assert property (p_lock)
		else $error("command launched while locked");

	property p_key_access_active_read;
		@(posedge i_ref_clk) disable iff (i_rst)
		(rd_acc && addr == ARRAY_OFS && s_q.key_access_active) |=>
			s_q.prdata == 32'hffffffff;
	endproperty
	a_key_access_active_read: assert property (p_key_access_active_read)
		else $error("array read valid during key access");

	property p_irq;
		@(posedge i_ref_clk) disable iff (i_rst)
		o_irq == ((s_q.be_ie && s_q.fl[s_q.bank_select].be) ||
			(s_q.cc_ie && s_q.fl[s_q.bank_select].cc));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not bank qualified");

	property p_prot;
		@(posedge i_ref_clk) disable iff (i_rst)
		!s_q.mode[MD_BDM] |=> $stable(s_q.prot);
	endproperty
	a_prot: assert property (p_prot)
		else $error("protection changed outside debug");

	property p_unsec;
		@(posedge i_ref_clk) disable iff (i_rst)
		($changed(s_q.sec) && $past(s_q.sec_loaded)) |->
			($past(s_q.key_idx) == 3'h4 && !$past(s_q.key_bad));
	endproperty
	a_unsec: assert property (p_unsec)
		else $error("unsecured without full key match");

	property p_launch;
		@(posedge i_ref_clk) disable iff (i_rst)
		(s_q.seq == ST_LOAD) |=> (s_q.seq == ST_RUN && s_q.hv &&
			!s_q.fl[s_q.bank_run].cc);
	endproperty
	a_launch: assert property (p_launch)
		else $error("launch did not start command");

	property p_sec_load;
		@(posedge i_ref_clk) disable iff (i_rst)
		!s_q.sec_loaded |=>
			s_q.sec == $past(i_security_option[1:0]);
	endproperty
	a_sec_load: assert property (p_sec_load)
		else $error("security not taken from option byte");

	property p_wait_run;
		@(posedge i_ref_clk) disable iff (i_rst)
		(s_q.mode[MD_WAIT] && s_q.seq == ST_RUN && s_q.cnt != CNT_W'(1) &&
			!stop_entry) |=> s_q.seq == ST_RUN;
	endproperty
	a_wait_run: assert property (p_wait_run)
		else $error("command abandoned in wait mode");

endmodule : flash_power_security_irq

// >>> tb_top.sv
/*
 * Self-checking bench for the flash supervisor: security, backdoor key,
 * command launch, wait, stop, debug and interrupt behaviour.
 * Assumes the host model drives the APB port and array words are constant.
 */
`timescale 1ns/1ps

module tb_top;
	import flash_ctl_pkg::*;
	localparam int          TICKS = 20;
	localparam logic [31:0] ARR   = 32'h0000_1111;
	localparam logic [63:0] KEY   = 64'h1234_5678_9abc_def0;
	localparam logic [7:0]  OPT   = 8'h83;

	logic        i_ref_clk;
	logic        i_rst;
	apb_req_t    req;
	apb_rsp_t    rsp;
	logic        irq;
	logic        hv;
	logic [1:0]  sec;
	logic [7:0]  opt;
	logic [31:0] r;
	logic        e;
	int          err_count;
	int          checked;
	int          cyc;

	flash_power_security_irq #(.CMD_TICKS(TICKS)) u_flash_power_security_irq (
		.i_ref_clk             (i_ref_clk),
		.i_rst                 (i_rst),
		.i_apb                 (req),
		.o_apb                 (rsp),
		.i_backdoor_key        (KEY),
		.i_security_option     (opt),
		.i_array_rdata         (ARR),
		.o_irq                 (irq),
		.o_high_voltage_on     (hv),
		.o_security_state_field(sec)
	);

	apb_host_model u_apb_host_model (
		.i_ref_clk(i_ref_clk),
		.i_apb    (rsp),
		.o_apb    (req)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	// A pass costs far less than this; the whole run is a few hundred.
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_apb_host_model.xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		u_apb_host_model.xfer(1'b0, a, 32'h0, r, e);
	endtask : rd

	task automatic launch(input logic [7:0] cmd);
		wr(ARRAY_OFS, {cmd, 24'h0});
		wr(STAT_OFS, 32'h1 << ST_BE);
		idle(2);
	endtask : launch

	task automatic wait_done;
		int n;
		n = 0;
		while (hv !== 1'b0 && n < 100) begin
			@(posedge i_ref_clk);
			n++;
		end
		chk(hv, 1'b0);
	endtask : wait_done

	// Key words go out in the slot order packed two bits per write.
	task automatic key_seq(input logic [63:0] k, input logic [7:0] ord);
		logic [1:0] ix;
		wr(CFG_OFS, 32'h1 << CFG_KEY_ACCESS_ACTIVE);
		for (int i = 0; i < 4; i++) begin
			ix = ord[2*i+:2];
			wr(KEY_OFS, {14'h0, ix, k[16*ix+:16]});
		end
		wr(CFG_OFS, 32'h0);
		idle(3);
	endtask : key_seq

	task automatic do_reset;
		i_rst <= 1'b1;
		idle(8);
		i_rst <= 1'b0;
	endtask : do_reset

	task automatic t_backdoor;
		chk(sec, 2'h3);
		wr(MODE_OFS, 32'h3);
		key_seq(KEY, 8'he4);
		chk(sec, 2'h3);
		wr(MODE_OFS, 32'h0);
		wr(CFG_OFS, 32'h1 << CFG_KEY_ACCESS_ACTIVE);
		rd(ARRAY_OFS);
		chk(r, 32'hffff_ffff);
		key_seq(KEY ^ 64'h0000_0001_0000_0000, 8'he4);
		chk(sec, 2'h3);
		key_seq(KEY, 8'hd8);
		chk(sec, 2'h3);
		key_seq(KEY, 8'he4);
		chk(sec, SEC_UNSECURE);
		rd(ARRAY_OFS);
		chk(r, ARR);
		rd(PROT_OFS);
		chk(r[7:0], PROT_RESET);
		rd(OPT_OFS);
		chk(r[7:0], OPT);
		$display("backdoor test done");
	endtask : t_backdoor

	task automatic t_cmd_wait_irq;
		launch(CMD_PROGRAM);
		chk(hv, 1'b1);
		rd(STAT_OFS);
		chk(r[ST_CC], 1'b0);
		wait_done();
		wr(MODE_OFS, 32'h1 << MD_WAIT);
		wr(CFG_OFS, 32'h1 << CFG_CC_IE);
		launch(CMD_SECT_ERASE);
		chk(irq, 1'b0);
		wait_done();
		idle(2);
		chk(irq, 1'b1);
		wr(CFG_OFS, 32'h1 << CFG_BE_IE);
		idle(2);
		chk(irq, 1'b1);
		wr(CFG_OFS, 32'h0);
		idle(2);
		chk(irq, 1'b0);
		wr(MODE_OFS, 32'h0);
		$display("command and wait test done");
	endtask : t_cmd_wait_irq

	task automatic t_stop;
		launch(CMD_PROGRAM);
		// The second command waits in the queue and fills the buffer.
		launch(CMD_PROGRAM);
		wr(MODE_OFS, 32'h1 << MD_STOP);
		idle(2);
		chk(hv, 1'b0);
		rd(STAT_OFS);
		chk({r[ST_CC], r[ST_AE]}, 2'h3);
		wr(MODE_OFS, 32'h0);
		rd(STAT_OFS);
		chk(r[ST_BE], 1'b1);
		launch(CMD_PROGRAM);
		chk(hv, 1'b0);
		wr(STAT_OFS, 32'h1 << ST_AE);
		launch(CMD_VERIFY);
		chk(hv, 1'b1);
		wait_done();
		$display("stop test done");
	endtask : t_stop

	task automatic t_debug_reset;
		wr(MODE_OFS, 32'h1 << MD_BDM);
		wr(PROT_OFS, 32'h5a);
		rd(PROT_OFS);
		chk(r[7:0], 8'h5a);
		rd(8'h40);
		chk(e, 1'b1);
		do_reset();
		chk(sec, 2'h3);
		wr(MODE_OFS, 32'h3);
		launch(CMD_PROGRAM);
		chk(hv, 1'b0);
		wr(STAT_OFS, (32'h1 << ST_AE) | (32'h1 << ST_PV));
		launch(CMD_MASS_ERASE);
		chk(hv, 1'b1);
		opt <= {OPT[7:2], SEC_UNSECURE};
		do_reset();
		chk(hv, 1'b0);
		idle(2);
		chk(sec, SEC_UNSECURE);
		$display("debug and reset test done");
	endtask : t_debug_reset

	initial begin
		err_count = 0;
		checked = 0;
		cyc = 0;
		opt = OPT;
		i_rst = 1'b1;
		idle(8);
		i_rst <= 1'b0;
		t_backdoor();
		t_cmd_wait_irq();
		t_stop();
		t_debug_reset();
		wrap_up();
	end
endmodule : tb_top
